// *** bench/hps_expander_model.sv ***
// expander bridge model: swaps one pin byte per serial sideband frame
`timescale 1ns/1ps
module hps_expander_model (
  // serial sideband
  output logic      sb_clk,
  output logic      sb_frame_n,
  output logic      sb_din,
  input  wire logic sb_dout
);
  initial begin
    sb_clk = 1'b0;
    sb_frame_n = 1'b1;
    sb_din = 1'b0;
  end
  // nbits other than 8 makes a frame the block must drop; clock idles low
  task automatic frame(input logic [7:0] pins, input int nbits, output logic [7:0] got);
    #1;
    sb_frame_n = 1'b0;
    sb_din = pins[0];
    for (int i = 0; i < nbits; i++) begin
      #24 sb_clk = 1'b1;
      got[i%8] = sb_dout;
      #24 sb_clk = 1'b0;
      sb_din = (i < 7) ? pins[i+1] : ~sb_din;
    end
    #24 sb_frame_n = 1'b1;
    // released line shows no stale level
    sb_din = ~sb_din;
    #200;
  endtask : frame
endmodule : hps_expander_model

// *** bench/hps_slot_hotplug_tb.sv ***
// self-checking bench for the slot hot-plug signal block
`timescale 1ns/1ps
`define CHK(n, e, s) begin \
  total_checks++; \
  if ((s) !== (e)) begin \
    n_errors++; \
    $display("ERROR %s exp %h got %h", n, e, s); \
  end end
module hps_slot_hotplug_tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, sb_clk, sb_frame_n;
  logic        sb_din, sb_dout, link_up, link_recovery_failed, link_gen5, irq, sb_update_req;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, c;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0]  got, sent;
  logic [3:0]  blk;
  logic [15:0] ctl;
  int          n_errors, total_checks, cyc, seed;
  localparam logic [3:0]  TCFG [9] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h2, 4'h2, 4'h2, 4'h2};
  localparam logic [7:0]  TPIN [9] = '{8'hef, 8'he7, 8'hd7, 8'haf, 8'hef, 8'he7, 8'he7, 8'haf,
                                       8'h8f};
  localparam logic [15:0] TST  [9] = '{16'h0068, 16'h0061, 16'h002b, 16'h004c, 16'h00c4,
                                       16'h0045, 16'h0044, 16'h0060, 16'h0042};

  hps_slot_hotplug #(.BLINK_HALF(8)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sb_clk, .sb_frame_n, .sb_din, .sb_dout,
    .sb_update_req, .link_up, .link_recovery_failed, .link_gen5, .irq);
  hps_expander_model xpd (.sb_clk, .sb_frame_n, .sb_din, .sb_dout);

  always #2 aclk = ~aclk;

  // hang guard, several times the expected run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      summarize();
    end
  end

  // pin byte the expander should receive for a control value
  function automatic logic [7:0] exp_pins(input logic [15:0] v);
    return {v[11], 4'hf, ~v[10], v[9:8] == 2'b01, v[7:6] == 2'b01};
  endfunction : exp_pins

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, link_up, link_recovery_failed, link_gen5} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h3;
    {n_errors, total_checks, cyc} = '0;
    seed = 88680;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, refused misaligned write, reference frame
    rdr(hps_pkg::ADDR_SLOT_CONTROL);
    `CHK("ctl_rst", {16'h0000, hps_pkg::CONTROL_RESET}, rd)
    wr(4'h1, 32'h0000_0c00);
    `CHK("bresp", hps_pkg::RESP_SLVERR, rsp)
    rdr(4'h2);
    `CHK("rd_err", {hps_pkg::RESP_SLVERR, 32'h0}, {rsp, rd})
    xpd.frame(8'hff, 8, got);
    `CHK("pins_rst", exp_pins(hps_pkg::CONTROL_RESET), got)
    sent = exp_pins(hps_pkg::CONTROL_RESET);
    rdr(hps_pkg::ADDR_SLOT_STATUS);
    `CHK("st_ref", 32'h0000_0020, rd)
    $display("test reset done");
    // random control values, blink code kept out of the pin compare
    for (int i = 0; i < 6; i++) begin
      c = $random(seed);
      ctl = {4'h0, c[1], c[0], c[2] ? 2'b01 : 2'b11, c[3] ? 2'b01 : 2'b11, 6'h00};
      wr(hps_pkg::ADDR_SLOT_CONTROL, {c[31:16], ctl});
      @(posedge aclk);
      `CHK("upd_req", exp_pins(ctl) != sent, sb_update_req)
      xpd.frame(8'hff, 8, got);
      `CHK("pins", exp_pins(ctl), got)
      `CHK("upd_idle", 1'b0, sb_update_req)
      sent = exp_pins(ctl);
    end
    // both indicators blinking: back-to-back frames sample both phases
    wr(hps_pkg::ADDR_SLOT_CONTROL, 32'h0000_0280);
    for (int i = 0; i < 4; i++) begin
      xpd.frame(8'hff, 8, got);
      blk[i] = got[0];
      `CHK("blink_pwr", got[0], got[1])
    end
    `CHK("blink", 1'b1, (blk != 4'h0) && (blk != 4'hf))
    $display("test outputs done");
    // input events, presence and link unmasked only
    wr(hps_pkg::ADDR_IRQ_MASK, 32'h0000_0108);
    wr(hps_pkg::ADDR_SLOT_STATUS, 32'h0000_012f);
    for (int i = 0; i < 9; i++) begin
      wr(hps_pkg::ADDR_CONFIG, {28'h0, TCFG[i]});
      xpd.frame(TPIN[i], 8, got);
      rdr(hps_pkg::ADDR_SLOT_STATUS);
      `CHK("status", {16'h0000, TST[i]}, rd)
      `CHK("irq", TST[i][3], irq)
      wr(hps_pkg::ADDR_SLOT_STATUS, 32'h0000_012f);
    end
    // a short frame is dropped
    xpd.frame(8'hff, 7, got);
    rdr(hps_pkg::ADDR_SLOT_STATUS);
    `CHK("short", 32'h0000_0040, rd)
    // card form at fifth generation: presence change not reported
    wr(hps_pkg::ADDR_CONFIG, 32'h0000_0008);
    link_gen5 <= 1'b1;
    xpd.frame(8'hff, 8, got);
    rdr(hps_pkg::ADDR_SLOT_STATUS);
    `CHK("gen5", 1'b0, rd[3])
    $display("test events done");
    // in-band: link up adds a card, failed recovery then down removes it
    wr(hps_pkg::ADDR_CONFIG, 32'h0000_0004);
    wr(hps_pkg::ADDR_SLOT_STATUS, 32'h0000_012f);
    link_up <= 1'b1;
    rdr(hps_pkg::ADDR_SLOT_STATUS);
    `CHK("link_add", 2'b11, {rd[13], rd[8]})
    `CHK("link_irq", 1'b1, irq)
    wr(hps_pkg::ADDR_SLOT_STATUS, 32'h0000_0100);
    link_recovery_failed <= 1'b1;
    @(posedge aclk);
    link_recovery_failed <= 1'b0;
    link_up <= 1'b0;
    rdr(hps_pkg::ADDR_SLOT_STATUS);
    `CHK("link_rm", 2'b01, {rd[13], rd[8]})
    $display("test link done");
    summarize();
  end
endmodule : hps_slot_hotplug_tb

// *** inc/hps_pkg.sv ***
// package: constants and types for the slot hot-plug signal block
package hps_pkg;
  // register byte addresses
  localparam logic [3:0]  ADDR_SLOT_CONTROL = 4'h0;
  localparam logic [3:0]  ADDR_SLOT_STATUS  = 4'h4;
  localparam logic [3:0]  ADDR_CONFIG       = 4'h8;
  localparam logic [3:0]  ADDR_IRQ_MASK     = 4'hc;
  // reset values: both indicators off, power off
  localparam logic [15:0] CONTROL_RESET     = 16'h03c0;
  localparam logic [3:0]  CONFIG_RESET      = 4'h0;
  localparam logic [15:0] MASK_RESET        = 16'h0000;
  // slot control fields
  localparam int          CTL_ATTN_LSB      = 6;
  localparam int          CTL_PWRIND_LSB    = 8;
  localparam int          CTL_PWR_CTRL      = 10;
  localparam int          CTL_INTERLOCK     = 11;
  // slot status fields
  localparam int          ST_BUTTON         = 0;
  localparam int          ST_PFAULT         = 1;
  localparam int          ST_LATCH_A        = 2;
  localparam int          ST_PRES_CHG       = 3;
  localparam int          ST_LATCH_B        = 5;
  localparam int          ST_PRES_STATE     = 6;
  localparam int          ST_INTERLOCK      = 7;
  localparam int          ST_LINK_CHG       = 8;
  localparam int          ST_LINK_STATE     = 13;
  // config fields
  localparam int          CFG_FORM_FACTOR   = 0;
  localparam int          CFG_STORAGE       = 1;
  localparam int          CFG_INBAND_EN     = 2;
  localparam int          CFG_CEM_CARD      = 3;
  // sideband frame
  localparam logic [3:0]  FRAME_BITS        = 4'h8;
  // timing
  localparam int          CLK_PERIOD_NS     = 4;
  localparam int          BLINK_HZ          = 1;
  localparam int          BLINK_HALF_CYC    = 1000000000 / (2 * BLINK_HZ * CLK_PERIOD_NS);
  // axi answers
  localparam logic [1:0]  RESP_OKAY         = 2'b00;
  localparam logic [1:0]  RESP_SLVERR       = 2'b10;
  // indicator codes
  localparam logic [1:0]  IND_ON            = 2'b01;
  localparam logic [1:0]  IND_BLINK         = 2'b10;
  localparam logic [1:0]  IND_OFF           = 2'b11;

  // expander pin byte, bit 0 first
  typedef struct packed {
    logic interlock_latch_drive;
    logic latch_sense;
    logic power_fault_n;
    logic presence_detect_n;
    logic button_n;
    logic slot_power_enable_n;
    logic power_indicator;
    logic attention_indicator;
  } hps_pins_t;

  typedef enum logic [2:0] {
    SB_IDLE  = 3'b001,
    SB_SHIFT = 3'b010,
    SB_DONE  = 3'b100
  } hps_sb_state_t;
endpackage : hps_pkg

// *** verilog/hps_slot_hotplug.sv ***
// slot hot-plug signal logic: registers, sideband shifter, event capture
// Function
// - attention indicator on pin 0 from control 7:6: on, 1 Hz blink, off.
// - power indicator on pin 1 from control 9:8, same encoding.
// - button low on pin 3 sets status bit 0.
// - presence pin 4 level kept in bit 6; any change sets bit 3.
// - power fault low on pin 5 sets status bit 1.
// - control bit 10 drives slot power enable low on pin 2.
// - form factor 0: pin 6 is retention latch, level bit 5, change bit 2.
// - form factor 1: pin 6 is interlock sense, level bit 7, change bit 2.
// - control bit 11 drives interlock latch output on pin 7.
// - storage use keeps the same pins; latch level moves to bit 2, latch change to bit 5.
// - storage: falling edge on pin 3 sets bit 0.
// - storage: falling edge on pin 5 sets bit 1.
// - storage: pin 6 level in bit 2, change sets bit 5.
// - presence change reports surprise removal and insertion, no button needed.
// - presence surprise unsupported for card form at fifth generation rate.
// - link-down after failed recovery is removal; later link-up is new card.
// - pins are read and written serially over the sideband port.
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module hps_slot_hotplug #(
  parameter int unsigned BLINK_HALF = hps_pkg::BLINK_HALF_CYC
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // sideband serial link to expander bridge
  input  wire logic        sb_clk,
  input  wire logic        sb_frame_n,
  input  wire logic        sb_din,
  output logic             sb_dout,
  output logic             sb_update_req,
  // link state from the port
  input  wire logic        link_up,
  input  wire logic        link_recovery_failed,
  input  wire logic        link_gen5,
  // interrupt
  output logic             irq
);
  logic [15:0]       ctl_q;
  logic [3:0]        cfg_q;
  logic [15:0]       mask_q;
  logic [4:0]        ev_q;      // button, fault, latch, presence, link
  logic [4:0]        ev_set;
  logic [4:0]        ev_clr;
  logic              pres_lvl_q;
  logic              latch_lvl_q;
  logic              link_lvl_q;
  logic [15:0]       status_word;
  logic [15:0]       ev_word;
  logic              storage;
  logic              ff_sel;

  assign storage = cfg_q[hps_pkg::CFG_STORAGE];
  assign ff_sel  = cfg_q[hps_pkg::CFG_FORM_FACTOR];

  // ---------------- blink timebase
  logic [26:0] blink_cnt_q;
  logic        blink_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink_cnt_q <= 27'h0;
      blink_q     <= 1'b0;
    end else if (blink_cnt_q == 27'(BLINK_HALF - 1)) begin
      blink_cnt_q <= 27'h0;
      blink_q     <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 27'h1;
    end
  end

  function automatic logic ind_level(input logic [1:0] code, input logic ph);
    ind_level = (code == hps_pkg::IND_ON) || ((code == hps_pkg::IND_BLINK) && ph);
  endfunction : ind_level

  // outgoing pin byte; input positions released high
  hps_pkg::hps_pins_t out_pins;
  always_comb begin
    out_pins                       = '1;
    out_pins.attention_indicator   = ind_level(ctl_q[7:6], blink_q);
    out_pins.power_indicator       = ind_level(ctl_q[9:8], blink_q);
    out_pins.slot_power_enable_n   = ~ctl_q[hps_pkg::CTL_PWR_CTRL];
    out_pins.interlock_latch_drive = ctl_q[hps_pkg::CTL_INTERLOCK];
  end

  // ---------------- sideband link, sampled on aclk
  logic [2:0] clk_s_q;
  logic [2:0] frm_s_q;
  logic [1:0] din_s_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_s_q <= 3'h0;
      frm_s_q <= 3'h7;
      din_s_q <= 2'h0;
    end else begin
      clk_s_q <= {clk_s_q[1:0], sb_clk};
      frm_s_q <= {frm_s_q[1:0], sb_frame_n};
      din_s_q <= {din_s_q[0], sb_din};
    end
  end
  logic sb_rise;
  logic sb_fall;
  logic frm_start;
  logic frm_end;
  assign sb_rise   = clk_s_q[1] & ~clk_s_q[2];
  assign sb_fall   = ~clk_s_q[1] & clk_s_q[2];
  assign frm_start = ~frm_s_q[1] & frm_s_q[2];
  assign frm_end   = frm_s_q[1] & ~frm_s_q[2];

  hps_pkg::hps_sb_state_t sb_st_q;
  logic [7:0]             sh_out_q;
  logic [7:0]             sh_in_q;
  logic [3:0]             bit_cnt_q;
  logic                   commit;
  assign commit = (sb_st_q == hps_pkg::SB_DONE);

  // serial pin exchange, bit 0 first; a short frame is dropped whole
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sb_st_q   <= hps_pkg::SB_IDLE;
      sh_out_q  <= 8'hff;
      sh_in_q   <= 8'h00;
      bit_cnt_q <= 4'h0;
      sb_dout   <= 1'b1;
    end else begin
      case (sb_st_q)
        hps_pkg::SB_IDLE: begin
          if (frm_start) begin
            sh_out_q  <= out_pins;
            sb_dout   <= out_pins[0];
            bit_cnt_q <= 4'h0;
            sb_st_q   <= hps_pkg::SB_SHIFT;
          end
        end
        hps_pkg::SB_SHIFT: begin
          if (frm_end) begin
            sb_st_q <= (bit_cnt_q == hps_pkg::FRAME_BITS) ? hps_pkg::SB_DONE
                                                          : hps_pkg::SB_IDLE;
            sb_dout <= 1'b1;
          end else if (sb_rise && bit_cnt_q != 4'hf) begin
            sh_in_q   <= {din_s_q[1], sh_in_q[7:1]};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (sb_fall) begin
            sh_out_q <= {1'b1, sh_out_q[7:1]};
            sb_dout  <= sh_out_q[1];
          end
        end
        hps_pkg::SB_DONE: sb_st_q <= hps_pkg::SB_IDLE;
        default:          sb_st_q <= hps_pkg::SB_IDLE;
      endcase
    end
  end

  // write request raised while the expander holds stale outputs
  logic [7:0] sent_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sent_q        <= 8'hff;
      sb_update_req <= 1'b0;
    end else begin
      if (sb_st_q == hps_pkg::SB_IDLE && frm_start) begin
        sent_q <= out_pins;
      end
      sb_update_req <= (out_pins != sent_q);
    end
  end

  // ---------------- input compare and events
  hps_pkg::hps_pins_t new_pins;
  hps_pkg::hps_pins_t prev_q;
  logic               first_q;
  logic               pres_ok;
  assign new_pins = sh_in_q;
  // presence surprise is refused for card form at fifth generation rate
  assign pres_ok  = ~(cfg_q[hps_pkg::CFG_CEM_CARD] & link_gen5);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q      <= '1;
      first_q     <= 1'b1;
      pres_lvl_q  <= 1'b0;
      latch_lvl_q <= 1'b0;
    end else if (commit) begin
      prev_q      <= new_pins;
      first_q     <= 1'b0;
      pres_lvl_q  <= ~new_pins.presence_detect_n;
      latch_lvl_q <= new_pins.latch_sense;
    end
  end

  logic link_prev_q;
  logic rec_fail_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_prev_q <= 1'b0;
      rec_fail_q  <= 1'b0;
      link_lvl_q  <= 1'b0;
    end else begin
      link_prev_q <= link_up;
      link_lvl_q  <= link_up;
      if (link_recovery_failed) begin
        rec_fail_q <= 1'b1;
      end else if (link_up && !link_prev_q) begin
        rec_fail_q <= 1'b0;
      end
    end
  end

  logic link_down_ev;
  logic link_add_ev;
  assign link_down_ev = link_prev_q & ~link_up & rec_fail_q;
  assign link_add_ev  = ~link_prev_q & link_up;

  always_comb begin
    ev_set = 5'h0;
    if (commit && !first_q) begin
      if (storage) begin
        ev_set[0] = prev_q.button_n & ~new_pins.button_n;
        ev_set[1] = prev_q.power_fault_n & ~new_pins.power_fault_n;
      end else begin
        ev_set[0] = ~new_pins.button_n;
        ev_set[1] = ~new_pins.power_fault_n;
      end
      ev_set[2] = prev_q.latch_sense ^ new_pins.latch_sense;
      ev_set[3] = pres_ok & (prev_q.presence_detect_n ^ new_pins.presence_detect_n);
    end
    ev_set[4] = cfg_q[hps_pkg::CFG_INBAND_EN] & (link_down_ev | link_add_ev);
  end

  // event positions in the status word; latch event moves in storage use
  always_comb begin
    ev_word                        = 16'h0;
    ev_word[hps_pkg::ST_BUTTON]    = ev_q[0];
    ev_word[hps_pkg::ST_PFAULT]    = ev_q[1];
    ev_word[hps_pkg::ST_PRES_CHG]  = ev_q[3];
    ev_word[hps_pkg::ST_LINK_CHG]  = ev_q[4];
    if (storage) begin
      ev_word[hps_pkg::ST_LATCH_B] = ev_q[2];
    end else begin
      ev_word[hps_pkg::ST_LATCH_A] = ev_q[2];
    end
  end

  always_comb begin
    status_word                          = ev_word;
    status_word[hps_pkg::ST_PRES_STATE]  = pres_lvl_q;
    status_word[hps_pkg::ST_LINK_STATE]  = link_lvl_q;
    if (storage) begin
      status_word[hps_pkg::ST_LATCH_A]   = latch_lvl_q;
    end else if (ff_sel) begin
      status_word[hps_pkg::ST_INTERLOCK] = latch_lvl_q;
    end else begin
      status_word[hps_pkg::ST_LATCH_B]   = latch_lvl_q;
    end
  end

  // ---------------- axi4-lite slave
  logic        aw_have_q;
  logic        w_have_q;
  logic [3:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        do_write;
  assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 4'h0;
      w_data_q      <= 32'h0;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= hps_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_have_q & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_have_q & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q[1:0] == 2'b00) ? hps_pkg::RESP_OKAY
                                                  : hps_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic [15:0] wmask;
  assign wmask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  logic wr_ok;
  assign wr_ok = do_write && (aw_addr_q[1:0] == 2'b00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q  <= hps_pkg::CONTROL_RESET;
      cfg_q  <= hps_pkg::CONFIG_RESET;
      mask_q <= hps_pkg::MASK_RESET;
    end else if (wr_ok) begin
      case (aw_addr_q)
        hps_pkg::ADDR_SLOT_CONTROL: ctl_q  <= (ctl_q & ~wmask) | (w_data_q[15:0] & wmask);
        hps_pkg::ADDR_IRQ_MASK:     mask_q <= (mask_q & ~wmask) | (w_data_q[15:0] & wmask);
        hps_pkg::ADDR_CONFIG: begin
          if (w_strb_q[0]) begin
            cfg_q <= w_data_q[3:0];
          end
        end
        default: ;
      endcase
    end
  end

  // write-one-to-clear; a new event in the same cycle wins
  logic [15:0] clr_word;
  assign clr_word = (wr_ok && aw_addr_q == hps_pkg::ADDR_SLOT_STATUS)
                    ? (w_data_q[15:0] & wmask) : 16'h0;
  always_comb begin
    ev_clr    = 5'h0;
    ev_clr[0] = clr_word[hps_pkg::ST_BUTTON];
    ev_clr[1] = clr_word[hps_pkg::ST_PFAULT];
    ev_clr[2] = storage ? clr_word[hps_pkg::ST_LATCH_B] : clr_word[hps_pkg::ST_LATCH_A];
    ev_clr[3] = clr_word[hps_pkg::ST_PRES_CHG];
    ev_clr[4] = clr_word[hps_pkg::ST_LINK_CHG];
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_q <= 5'h0;
    end else begin
      ev_q <= (ev_q & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ev_word & mask_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= hps_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= hps_pkg::RESP_OKAY;
        case (s_axi_araddr)
          hps_pkg::ADDR_SLOT_CONTROL: s_axi_rdata <= {16'h0, ctl_q};
          hps_pkg::ADDR_SLOT_STATUS:  s_axi_rdata <= {16'h0, status_word};
          hps_pkg::ADDR_CONFIG:       s_axi_rdata <= {28'h0, cfg_q};
          hps_pkg::ADDR_IRQ_MASK:     s_axi_rdata <= {16'h0, mask_q};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= hps_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------- assertions
  property p_attn_on;
    @(posedge aclk) disable iff (!aresetn)
      ctl_q[7:6] == hps_pkg::IND_ON |-> out_pins.attention_indicator;
  endproperty
  a_attn_on: assert property (p_attn_on) else $error("attention not lit");

  property p_pwrind_off;
    @(posedge aclk) disable iff (!aresetn)
      ctl_q[9:8] == hps_pkg::IND_OFF |-> !out_pins.power_indicator;
  endproperty
  a_pwrind_off: assert property (p_pwrind_off) else $error("power ind lit");

  property p_button;
    @(posedge aclk) disable iff (!aresetn)
      commit && !first_q && !storage && !new_pins.button_n |=> ev_q[0];
  endproperty
  a_button: assert property (p_button) else $error("button event lost");

  property p_pres_chg;
    @(posedge aclk) disable iff (!aresetn)
      commit && !first_q && pres_ok
      && (prev_q.presence_detect_n != new_pins.presence_detect_n)
      |=> ev_q[3] && (pres_lvl_q == ~$past(new_pins.presence_detect_n));
  endproperty
  a_pres_chg: assert property (p_pres_chg) else $error("presence event lost");

  property p_pf_storage;
    @(posedge aclk) disable iff (!aresetn)
      commit && !first_q && storage && prev_q.power_fault_n && !new_pins.power_fault_n
      |=> ev_q[1];
  endproperty
  a_pf_storage: assert property (p_pf_storage) else $error("power loss lost");

  property p_slot_power_enable_n;
    @(posedge aclk) disable iff (!aresetn)
      out_pins.slot_power_enable_n == !ctl_q[hps_pkg::CTL_PWR_CTRL];
  endproperty
  a_slot_power_enable_n: assert property (p_slot_power_enable_n) else $error("power enable wrong");

  property p_latch_std;
    @(posedge aclk) disable iff (!aresetn)
      !storage && !ff_sel |-> status_word[hps_pkg::ST_LATCH_B] == latch_lvl_q
                              && status_word[hps_pkg::ST_LATCH_A] == ev_q[2];
  endproperty
  a_latch_std: assert property (p_latch_std) else $error("latch map wrong");

  property p_link_down;
    @(posedge aclk) disable iff (!aresetn)
      link_down_ev && cfg_q[hps_pkg::CFG_INBAND_EN] |=> ev_q[4] ##1 irq || !mask_q[8];
  endproperty
  a_link_down: assert property (p_link_down) else $error("link down lost");

  property p_frame_load;
    @(posedge aclk) disable iff (!aresetn)
      sb_st_q == hps_pkg::SB_IDLE && frm_start |=> sh_out_q == $past(out_pins) && sb_dout
      == $past(out_pins.attention_indicator);
  endproperty
  a_frame_load: assert property (p_frame_load) else $error("frame load wrong");

  c_commit:    cover property (@(posedge aclk) disable iff (!aresetn) commit && !first_q);
  c_irq:       cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
  c_storage:   cover property (@(posedge aclk) disable iff (!aresetn) storage && ev_set[0]);
endmodule : hps_slot_hotplug
